// *** pidiv_pkg.sv ***
// pidiv_pkg: constants and carrier types of the periodic interrupt divider
// assumes: used by pidiv_top, pidiv_sva and pidiv_top_bench, every reference written as pidiv_pkg::name
package pidiv_pkg;

  // register map, byte offsets on the wishbone bus
  localparam logic [7:0] CTRL_IDX      = 8'h07;             // printed index of the control reg
  localparam logic [5:0] CTRL_ADDR     = 6'h1c;             // byte address = 4 * index
  localparam logic [5:0] MISC_ADDR     = 6'h20;             // debug/pseudo-stop enables
  localparam logic [5:0] STAT_ADDR     = 6'h24;             // sticky event status, read only
  localparam logic [5:0] CLR_ADDR      = 6'h28;             // write one to clear status
  localparam logic [5:0] IEN_ADDR      = 6'h2c;             // interrupt enable

  // control register fields and reset
  localparam int         DEC_BIT       = 7;
  localparam int         RATE_HI       = 6;
  localparam int         RATE_LO       = 4;
  localparam int         MOD_HI        = 3;
  localparam int         MOD_LO        = 0;
  localparam logic [7:0] CTRL_RST      = 8'h00;

  // misc register fields and reset
  localparam int         PSTOP_EN_BIT  = 0;
  localparam int         DBG_STOP_BIT  = 1;
  localparam logic [1:0] MISC_RST      = 2'h0;

  // status layout: bit 0 is the timeout event
  localparam int         EVT_TIMEOUT   = 0;
  localparam logic [0:0] STAT_RST      = 1'h0;

  // binary family: base exponent 10 for rate code 1
  localparam int         BIN_EXP_BASE  = 10;
  localparam int         DEC_UNIT      = 1000;
  localparam int         PRE_W         = 18;                // holds 200000 - 1

  // wishbone request carried as one struct
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pidiv_wb_req_t;

endpackage : pidiv_pkg

// *** pidiv_top.sv ***
// pidiv_top: periodic interrupt divider with wishbone register slave
// assumes: clk_i is the oscillator clock; mode inputs come from pins in other domains
//
// Function
// - timeout event recurs every selected divide value oscillator cycles
// - any control register write restarts the counter from its initial state
// - bit 7 chooses binary or decimal prescale family
// - bits 6 to 4 pick the coarse prescale rate
// - bits 3 to 0 multiply the prescaled period by n plus one
// - counter runs on the oscillator clock, not the pll clock
// - binary code 000 is off, codes 001-111 give two to 10..16
// - decimal codes give 1,2,5,10,20,50,100,200 thousand base periods
// - reset leaves binary mode, rate zero, modulus zero: timer off
// - in pseudo stop, counting continues only when enabled, else freezes
// - debug-stop bit halts the counter during active background debug
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
module pidiv_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // chip mode inputs, asynchronous
  input  wire logic        pseudo_stop_i,
  input  wire logic        debug_active_i,
  // events
  output logic             timeout_o,
  output logic             irq_o
);

  typedef enum logic [0:0] {PIDIV_IDLE, PIDIV_ACKED} pidiv_bus_t;

  pidiv_pkg::pidiv_wb_req_t req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  // base period in cycles, minus one, for a family and rate code
  function automatic logic [pidiv_pkg::PRE_W-1:0] base_m1(input logic dec,
                                                          input logic [2:0] rate);
    logic [31:0] v;
    v = 32'h1;
    if (dec) begin
      case (rate)
        3'h0:    v = 32'd1 * pidiv_pkg::DEC_UNIT;
        3'h1:    v = 32'd2 * pidiv_pkg::DEC_UNIT;
        3'h2:    v = 32'd5 * pidiv_pkg::DEC_UNIT;
        3'h3:    v = 32'd10 * pidiv_pkg::DEC_UNIT;
        3'h4:    v = 32'd20 * pidiv_pkg::DEC_UNIT;
        3'h5:    v = 32'd50 * pidiv_pkg::DEC_UNIT;
        3'h6:    v = 32'd100 * pidiv_pkg::DEC_UNIT;
        default: v = 32'd200 * pidiv_pkg::DEC_UNIT;
      endcase
    end else begin
      v = 32'h1 << (pidiv_pkg::BIN_EXP_BASE - 1 + 32'(rate));
    end
    base_m1 = pidiv_pkg::PRE_W'(v - 32'h1);
  endfunction : base_m1

  // registers
  logic [7:0]                    ctrl_ff;
  logic [1:0]                    misc_ff;
  logic [0:0]                    stat_ff;
  logic [0:0]                    ien_ff;
  logic [pidiv_pkg::PRE_W-1:0]   pre_ff;
  logic [3:0]                    mod_ff;
  logic                          tmo_ff;
  logic [1:0]                    pst_sync_ff;
  logic [1:0]                    dbg_sync_ff;
  pidiv_bus_t                    bus_ff;
  logic [31:0]                   rdat_ff;

  // decode
  wire access   = req.cyc && req.stb && (bus_ff == PIDIV_IDLE);
  wire wr       = access && req.we;
  wire wr_ctrl  = wr && (req.adr == pidiv_pkg::CTRL_ADDR) && req.sel[0];
  wire wr_misc  = wr && (req.adr == pidiv_pkg::MISC_ADDR) && req.sel[0];
  wire wr_clr   = wr && (req.adr == pidiv_pkg::CLR_ADDR) && req.sel[0];
  wire wr_ien   = wr && (req.adr == pidiv_pkg::IEN_ADDR) && req.sel[0];

  // control fields
  // family select bit
  wire       dec_sel  = ctrl_ff[pidiv_pkg::DEC_BIT];
  wire [2:0] rate_sel = ctrl_ff[pidiv_pkg::RATE_HI:pidiv_pkg::RATE_LO];
  wire [3:0] mod_sel  = ctrl_ff[pidiv_pkg::MOD_HI:pidiv_pkg::MOD_LO];
  // binary rate zero turns timer off
  wire       timer_on = dec_sel || (rate_sel != 3'h0);
  wire [pidiv_pkg::PRE_W-1:0] pre_top = base_m1(dec_sel, rate_sel);

  // synchronised mode levels; only the second stage is read
  wire pst_s = pst_sync_ff[1];
  wire dbg_s = dbg_sync_ff[1];
  wire frz_pst = pst_s && !misc_ff[pidiv_pkg::PSTOP_EN_BIT];
  // debug stop freezes while debug active
  wire frz_dbg = dbg_s && misc_ff[pidiv_pkg::DBG_STOP_BIT];
  wire run     = timer_on && !frz_pst && !frz_dbg;

  wire pre_end = (pre_ff == pre_top);
  wire mod_end = (mod_ff == mod_sel);
  wire hit     = run && pre_end && mod_end;

  // next counter values; a freeze holds state without reinitialising
  logic [pidiv_pkg::PRE_W-1:0] nxt_pre;
  logic [3:0]                  nxt_mod;
  always_comb begin
    nxt_pre = pre_ff;
    nxt_mod = mod_ff;
    if (wr_ctrl || !timer_on) begin
      nxt_pre = '0;
      nxt_mod = 4'h0;
    end else if (run) begin
      if (pre_end) begin
        nxt_pre = '0;
        nxt_mod = mod_end ? 4'h0 : mod_ff + 4'h1;
      end else begin
        nxt_pre = pre_ff + 1'b1;
      end
    end
  end

  // counters clocked by the oscillator clock clk_i
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_ff <= '0;
      mod_ff <= 4'h0;
      tmo_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      mod_ff <= nxt_mod;
      tmo_ff <= hit && !wr_ctrl;
    end
  end

  // two-stage synchronisers for the asynchronous mode pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pst_sync_ff <= 2'h0;
      dbg_sync_ff <= 2'h0;
    end else begin
      pst_sync_ff <= {pst_sync_ff[0], pseudo_stop_i};
      dbg_sync_ff <= {dbg_sync_ff[0], debug_active_i};
    end
  end

  // software registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= pidiv_pkg::CTRL_RST;
      misc_ff <= pidiv_pkg::MISC_RST;
      ien_ff  <= 1'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= req.dat[7:0];
      end
      if (wr_misc) begin
        misc_ff <= req.dat[1:0];
      end
      if (wr_ien) begin
        ien_ff <= req.dat[0:0];
      end
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  wire [0:0] clr_mask = wr_clr ? req.dat[0:0] : 1'h0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_ff <= pidiv_pkg::STAT_RST;
    end else begin
      stat_ff <= (stat_ff & ~clr_mask) | tmo_ff;
    end
  end

  // read mux; unmapped addresses read zero and still ack
  logic [31:0] rd_mux;
  always_comb begin
    case (req.adr)
      pidiv_pkg::CTRL_ADDR: rd_mux = {24'h0, ctrl_ff};
      pidiv_pkg::MISC_ADDR: rd_mux = {30'h0, misc_ff};
      pidiv_pkg::STAT_ADDR: rd_mux = {31'h0, stat_ff};
      pidiv_pkg::IEN_ADDR:  rd_mux = {31'h0, ien_ff};
      default:              rd_mux = 32'h0;
    endcase
  end

  // one-cycle ack, then one idle cycle so ack drops before a new request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_ff  <= PIDIV_IDLE;
      rdat_ff <= 32'h0;
    end else begin
      case (bus_ff)
        PIDIV_IDLE: begin
          if (req.cyc && req.stb) begin
            bus_ff  <= PIDIV_ACKED;
            rdat_ff <= rd_mux;
          end
        end
        PIDIV_ACKED: begin
          bus_ff <= PIDIV_IDLE;
        end
        default: begin
          bus_ff <= PIDIV_IDLE;
        end
      endcase
    end
  end

  // outputs
  assign wb_ack_o  = (bus_ff == PIDIV_ACKED);
  assign wb_dat_o  = rdat_ff;
  assign timeout_o = tmo_ff;
  assign irq_o     = |(stat_ff & ien_ff);

endmodule : pidiv_top

// *** pidiv_sva.sv ***
// pidiv_sva: port assertions for the periodic interrupt divider
// assumes: bound to pidiv_top, one clock domain
`timescale 1ns/100ps
module pidiv_sva (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // modes and events
  input wire logic        pseudo_stop_i,
  input wire logic        debug_active_i,
  input wire logic        timeout_o,
  input wire logic        irq_o
);
  logic wr_ctrl;
  logic wr_ien;
  logic rd_zero;
  logic ien_ff;
  logic off_ff;
  // decode at the ack edge; the design took the write one cycle earlier
  assign wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == pidiv_pkg::CTRL_ADDR;
  assign wr_ien  = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == pidiv_pkg::IEN_ADDR;
  assign rd_zero = !(wb_adr_i inside {pidiv_pkg::CTRL_ADDR, pidiv_pkg::MISC_ADDR,
                                      pidiv_pkg::STAT_ADDR, pidiv_pkg::IEN_ADDR});
  // shadows lag the design, so they only gate checks, never predict edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ien_ff <= 1'b0;
      off_ff <= 1'b1;
    end else if (wr_ctrl) begin
      off_ff <= wb_dat_i[7:4] == 4'h0;
    end else if (wr_ien) begin
      ien_ff <= wb_dat_i[0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctrl_wr;
    wr_ctrl;
  endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  chk_tick_gap: assert property (timeout_o |=> !timeout_o [*8])
    else $error("timeout repeats too soon");
  chk_wr_restart: assert property (s_ctrl_wr |=> !timeout_o [*8])
    else $error("timeout right after control write");
  chk_off_quiet: assert property (off_ff |-> !timeout_o)
    else $error("timeout while off");
  chk_irq_raise: assert property (timeout_o && ien_ff |-> ##[0:2] irq_o)
    else $error("irq not raised");
  chk_irq_masked: assert property (!ien_ff && !wb_ack_o |-> !irq_o) else $error("irq masked");
  chk_rd_unmapped: assert property (wb_ack_o && !wb_we_i && rd_zero |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : pidiv_sva

// *** pidiv_top_bench.sv ***
// pidiv_top_bench: directed bench for the periodic interrupt divider
// assumes: 10 MHz clock, design and checker compiled first
`timescale 1ns/100ps
module pidiv_top_bench;
  logic        clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        pseudo_stop_i, debug_active_i, timeout_o, irq_o;
  int          n_mismatch, cmp_count;
  logic [7:0]  cv [8] = '{8'h10, 8'h11, 8'h20, 8'h80, 8'h91, 8'ha0, 8'h0f, 8'h00};
  int          nv [8] = '{1024, 2048, 2048, 1000, 4000, 5000, 0, 0};
  // device under test
  pidiv_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pseudo_stop_i(pseudo_stop_i),
    .debug_active_i(debug_active_i), .timeout_o(timeout_o), .irq_o(irq_o));
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task results;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is seen, then one idle cycle
  task bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      results();
    end
    rd = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // program ctrl, time the first event (freezing fz cycles), then one period
  task per(input logic [7:0] c, input int n, input int fz, input logic [1:0] m);
    int k;
    int j;
    bus(1'b1, pidiv_pkg::CTRL_ADDR, {24'h0, c});
    k = 0;
    j = 0;
    do begin
      @(posedge clk_i);
      k++;
      if (k == 100) {debug_active_i, pseudo_stop_i} <= m;
      else if (k == 100 + fz) {debug_active_i, pseudo_stop_i} <= 2'b00;
      @(negedge clk_i);
    end while (timeout_o !== 1'b1 && k < n + fz + 3000);
    // the write lands at the bus's first edge, the task returns two edges later,
    // and the design pulses timeout_o n edges after the write, so k ends at n - 2
    chk(timeout_o === 1'b1 ? k : 0, n != 0 ? n - 2 + fz : 0);
    if (n != 0) begin
      do begin
        @(posedge clk_i);
        j++;
        @(negedge clk_i);
      end while (timeout_o !== 1'b1 && j < n + 10);
      chk(j, n);
      if (timeout_o !== 1'b1) results();
    end
  endtask : per
  initial begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, pseudo_stop_i, debug_active_i} = 6'h00;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    // reset value, then reads that must return zero
    bus(1'b0, pidiv_pkg::CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, pidiv_pkg::CLR_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    // both families, several rates and moduli, and the off codes
    for (int i = 0; i < 8; i++) per(cv[i], nv[i], 0, 2'b00);
    $display("test periods done");
    bus(1'b1, pidiv_pkg::IEN_ADDR, 32'h1);
    bus(1'b1, pidiv_pkg::CTRL_ADDR, 32'h10);
    repeat (600) @(posedge clk_i);
    per(8'h10, 1024, 0, 2'b00);
    bus(1'b1, pidiv_pkg::MISC_ADDR, 32'h0);
    per(8'h80, 1000, 100, 2'b01);
    bus(1'b1, pidiv_pkg::MISC_ADDR, 32'h2);
    per(8'h80, 1000, 50, 2'b10);
    $display("test restart and freeze done");
    // sticky status, mask and clear with the timer stopped
    bus(1'b1, pidiv_pkg::CTRL_ADDR, 32'h0);
    bus(1'b0, pidiv_pkg::STAT_ADDR, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, pidiv_pkg::IEN_ADDR, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, pidiv_pkg::CLR_ADDR, 32'h1);
    bus(1'b0, pidiv_pkg::STAT_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test interrupt done");
    results();
  end
endmodule : pidiv_top_bench
bind pidiv_top pidiv_sva chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .pseudo_stop_i(pseudo_stop_i), .debug_active_i(debug_active_i), .timeout_o(timeout_o));
